// File: tile_mem_pkg.sv
// tile memory side constants: prefetchers, forwarding, split handling
// assumes one core clock, synchronous active-high reset
package tile_mem_pkg;
	// ==========================================================
	// address geometry
	localparam int ADDR_W      = 32;
	localparam int PC_W        = 16;
	localparam int LINE_LSB    = 6;   // 64-byte lines
	localparam int PAGE_LSB    = 12;  // 4k pages
	localparam int SET_W       = 6;   // bits 11:6
	localparam int STREAMS     = 48;
	localparam int STREAM_W    = 6;
	localparam int IPP_IDX_W   = 5;   // 32 table entries
	localparam int TRAIN_HITS  = 2;   // matching strides before issue
	localparam int SQ_DEPTH    = 4;   // store queue entries
	localparam int SQ_W        = 2;
	localparam int FILL_N      = 4;   // fill buffer entries
	localparam int SPLIT_CYC   = 2;   // cycles of a split access
	// ==========================================================
	// access kinds
	typedef enum logic [1:0] {
		KIND_INT = 2'h0,
		KIND_VEC = 2'h1,
		KIND_X87 = 2'h2,
		KIND_PKD = 2'h3
	} kind_type;
	// ==========================================================
	// pipeline states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SPLIT = 3'b010,
		ST_STALL = 3'b100
	} pipe_type;
endpackage

// File: stream_detector.sv
// one l2 stream detector tracking a single 4 KB region
// assumes line addresses already taken from the requesting access
`timescale 1ns/1ps
module stream_detector (
	input  wire logic                        ref_clk,
	input  wire logic                        srst,
	input  wire logic                        obsValid,   // access seen by this detector
	input  wire logic                        alloc,      // take a new region
	input  wire logic [tile_mem_pkg::ADDR_W-1:0] obsAddr,
	output logic                             hit,        // access falls in region
	output logic                             pfValid,
	output logic [tile_mem_pkg::ADDR_W-1:0]  pfAddr
);
	// ==========================================================
	// state
	logic                                        valid_r, valid_nxt;
	logic [tile_mem_pkg::ADDR_W-1:0]             last_r, last_nxt;   // last line address
	logic [1:0]                                  dir_r, dir_nxt;     // 01 up, 10 down
	logic                                        inRegion;
	logic                                        up, down;
	logic [tile_mem_pkg::ADDR_W-1:0]             nextLine;
	localparam logic [tile_mem_pkg::ADDR_W-1:0] LINE_STEP = 32'h0000_0040;

	assign inRegion = valid_r && (obsAddr[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::PAGE_LSB] ==
		last_r[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::PAGE_LSB]);
	assign hit  = inRegion;
	// only a one-line step counts as stream progress
	assign up   = inRegion && (obsAddr[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::LINE_LSB] ==
		last_r[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::LINE_LSB] + 26'h000_0001);
	assign down = inRegion && (obsAddr[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::LINE_LSB] ==
		last_r[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::LINE_LSB] - 26'h000_0001);
	assign nextLine = (dir_nxt == 2'h1) ? obsAddr + LINE_STEP : obsAddr - LINE_STEP;

	// ==========================================================
	// next state
	always_comb begin
		valid_nxt = valid_r;
		last_nxt  = last_r;
		dir_nxt   = dir_r;
		if (alloc) begin
			valid_nxt = 1'b1;
			last_nxt  = obsAddr;
			dir_nxt   = 2'h0;
		end else if (obsValid && inRegion) begin
			last_nxt = obsAddr;
			dir_nxt  = up ? 2'h1 : (down ? 2'h2 : 2'h0);
		end
	end

	// a prefetch leaves only when the next line keeps to the region
	assign pfValid = obsValid && !alloc && inRegion && (up || down) &&
		(nextLine[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::PAGE_LSB] ==
		obsAddr[tile_mem_pkg::ADDR_W-1:tile_mem_pkg::PAGE_LSB]);
	assign pfAddr = nextLine;

	// registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			valid_r <= 1'b0;
			last_r  <= 32'h0000_0000;
			dir_r   <= 2'h0;
		end else begin
			valid_r <= valid_nxt;
			last_r  <= last_nxt;
			dir_r   <= dir_nxt;
		end
	end

	AST_STREAM_PAGE: assert property (@(posedge ref_clk) disable iff (srst)
		pfValid |-> pfAddr[31:12] == obsAddr[31:12])
		else $error("stream prefetch left its region");
endmodule

// File: fwd_check.sv
// store-to-load forwarding decision against one store queue entry
// assumes the entry is older than the load being checked
`timescale 1ns/1ps
module fwd_check (
	input  wire logic                       stValid,
	input  wire logic [11:0]                stLow,     // store address bits 11:0
	input  wire logic [2:0]                 stSize,    // log2 bytes
	input  wire tile_mem_pkg::kind_type     stKind,
	input  wire logic                       stMasked,
	input  wire logic [11:0]                ldLow,
	input  wire logic [2:0]                 ldSize,
	input  wire tile_mem_pkg::kind_type     ldKind,
	output logic                            canFwd,
	output logic                            conflict
);
	logic [12:0] stEnd, ldEnd;
	logic        overlap, sameFamily;

	// only the low twelve bits and the sizes take part
	assign stEnd   = {1'b0, stLow} + (13'h0001 << stSize);
	assign ldEnd   = {1'b0, ldLow} + (13'h0001 << ldSize);
	assign overlap = stValid && ({1'b0, ldLow} < stEnd) && ({1'b0, stLow} < ldEnd);
	// vector and integer kinds never forward to each other
	assign sameFamily = (stKind == ldKind);
	assign canFwd = overlap && sameFamily && !stMasked && (stLow == ldLow) &&
		(ldSize <= stSize);
	assign conflict = overlap && !canFwd;
endmodule

// File: tile_prefetch_and_store_forwarding.sv
// tile memory side: prefetchers, in-order memory uop dispatch, forwarding
// assumes the core keeps requests stable while uopReady is low
`timescale 1ns/1ps
module tile_prefetch_and_store_forwarding (
	input  wire logic                        ref_clk,
	input  wire logic                        srst,
	// memory uop from the scheduler, program order
	input  wire logic                        uopValid,
	input  wire logic                        uopIsStore,
	input  wire logic [31:0]                 uopAddr,
	input  wire logic [2:0]                  uopSize,     // log2 bytes, up to 128
	input  wire tile_mem_pkg::kind_type      uopKind,
	input  wire logic                        uopMasked,   // vector store with lane mask
	input  wire logic                        uopCacheable,
	input  wire logic [15:0]                 uopPc,
	input  wire logic                        uopThread,
	input  wire logic                        uopSwPf,     // software prefetch
	input  wire logic                        uopSwPfL1,   // prefetch target l1
	input  wire logic                        tlbHit,
	input  wire logic                        storeDrained, // oldest store reached memory
	input  wire logic                        fillDone,    // one fill completes
	input  wire logic                        l2PfMiss,    // last l2 prefetch missed
	input  wire logic                        pfFault,     // last prefetch faulted
	output logic                             uopReady,
	output logic                             ldDone,
	output logic                             ldForwarded,
	output logic [5:0]                       l1Set,
	output logic                             splitOut,
	output logic                             walkReq,
	output logic                             l1PfValid,
	output logic [31:0]                      l1PfAddr,
	output logic                             l2PfValid,
	output logic [31:0]                      l2PfAddr,
	output logic                             memPfValid,
	output logic [31:0]                      memPfAddr,
	output logic [2:0]                       fillUsed
);
	// ==========================================================
	// pipeline state
	tile_mem_pkg::pipe_type state_r, state_nxt;
	logic        isSplit;
	logic        anyFwd, anyConf;
	logic [tile_mem_pkg::SQ_DEPTH-1:0] fwdVec, confVec;
	logic        take;                         // uop accepted this cycle
	logic        offer;                        // offered and not answered this cycle

	// split when last byte sits on another line or page
	logic [31:0] lastByte;
	assign lastByte = uopAddr + ((32'h0000_0001 << uopSize) - 32'h0000_0001);
	assign isSplit  = lastByte[31:tile_mem_pkg::LINE_LSB] !=
		uopAddr[31:tile_mem_pkg::LINE_LSB];

	// ==========================================================
	// store queue: oldest at index 0, drained one by one
	logic [tile_mem_pkg::SQ_DEPTH-1:0] sqV_r, sqV_nxt;
	logic [11:0]              sqLow_r [tile_mem_pkg::SQ_DEPTH];
	logic [2:0]               sqSize_r [tile_mem_pkg::SQ_DEPTH];
	tile_mem_pkg::kind_type   sqKind_r [tile_mem_pkg::SQ_DEPTH];
	logic [tile_mem_pkg::SQ_DEPTH-1:0] sqMask_r;

	genvar g;
	generate
		for (g = 0; g < tile_mem_pkg::SQ_DEPTH; g++) begin : g_fwd
			fwd_check u_chk (
				.stValid  (sqV_r[g]),
				.stLow    (sqLow_r[g]),
				.stSize   (sqSize_r[g]),
				.stKind   (sqKind_r[g]),
				.stMasked (sqMask_r[g]),
				.ldLow    (uopAddr[11:0]),
				.ldSize   (uopSize),
				.ldKind   (uopKind),
				.canFwd   (fwdVec[g]),
				.conflict (confVec[g])
			);
		end
	endgenerate
	assign anyConf = !uopIsStore && !uopSwPf && (|confVec);
	assign anyFwd  = !uopIsStore && !uopSwPf && (|fwdVec) && !anyConf;
	// stores stall while the queue is full; l1 software prefetch needs a fill entry
	logic [2:0] fillUsed_r, fillUsed_nxt;     // occupied fill entries
	logic sqFull, fillFull;
	assign sqFull   = sqV_r[tile_mem_pkg::SQ_DEPTH-1];
	assign fillFull = fillUsed_r == 3'(tile_mem_pkg::FILL_N);

	// ==========================================================
	// dispatch control, one uop at a time in order
	logic blocked;
	assign blocked = anyConf || (uopIsStore && sqFull) ||
		(uopSwPf && uopSwPfL1 && fillFull);
	// the core still holds a uop in its answer cycle; taking it again would run it twice
	assign offer = uopValid && !uopReady;
	always_comb begin
		state_nxt = state_r;
		take      = 1'b0;
		case (state_r)
			tile_mem_pkg::ST_IDLE: begin
				if (offer && blocked) begin
					state_nxt = tile_mem_pkg::ST_STALL;
				end else if (offer && isSplit) begin
					state_nxt = tile_mem_pkg::ST_SPLIT;
				end else if (offer) begin
					take = 1'b1;
				end
			end
			tile_mem_pkg::ST_SPLIT: begin
				take      = 1'b1;                      // second half
				state_nxt = tile_mem_pkg::ST_IDLE;
			end
			tile_mem_pkg::ST_STALL: begin
				if (!blocked) begin
					state_nxt = tile_mem_pkg::ST_IDLE;
				end
			end
			default: state_nxt = tile_mem_pkg::ST_IDLE;
		endcase
	end

	// store queue next values: push on store take, pop on drain
	logic pop, push;
	assign pop  = storeDrained && sqV_r[0];
	assign push = take && uopIsStore;
	always_comb begin
		sqV_nxt = pop ? (sqV_r >> 1) : sqV_r;
		if (push) begin
			sqV_nxt = {sqV_nxt[tile_mem_pkg::SQ_DEPTH-2:0], 1'b1};
		end
	end
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sqV_r    <= 4'h0;
			sqMask_r <= 4'h0;
			for (int i = 0; i < tile_mem_pkg::SQ_DEPTH; i++) begin
				sqLow_r[i]  <= 12'h000;
				sqSize_r[i] <= 3'h0;
				sqKind_r[i] <= tile_mem_pkg::KIND_INT;
			end
		end else begin
			sqV_r <= sqV_nxt;
			for (int i = 0; i < tile_mem_pkg::SQ_DEPTH; i++) begin
				// shift entries down on pop, new store lands at the top valid slot
				if (pop && i < tile_mem_pkg::SQ_DEPTH-1) begin
					sqLow_r[i]  <= sqLow_r[i+1];
					sqSize_r[i] <= sqSize_r[i+1];
					sqKind_r[i] <= sqKind_r[i+1];
					sqMask_r[i] <= sqMask_r[i+1];
				end
				// the new store takes the highest valid slot left after any pop
				if (push && sqV_nxt[i] && (i == tile_mem_pkg::SQ_DEPTH-1 ||
					!sqV_nxt[(i+1) % tile_mem_pkg::SQ_DEPTH])) begin
					sqLow_r[i]  <= uopAddr[11:0];
					sqSize_r[i] <= uopSize;
					sqKind_r[i] <= uopKind;
					sqMask_r[i] <= uopMasked;
				end
			end
		end
	end

	// ==========================================================
	// fill buffer occupancy for l1 software prefetches
	always_comb begin
		fillUsed_nxt = fillUsed_r;
		if (take && uopSwPf && uopSwPfL1) begin
			fillUsed_nxt = fillUsed_nxt + 3'h1;
		end
		if (fillDone && fillUsed_r != 3'h0) begin
			fillUsed_nxt = fillUsed_nxt - 3'h1;
		end
	end

	// ==========================================================
	// core prefetcher: table indexed by pc and thread
	logic [tile_mem_pkg::IPP_IDX_W-1:0] ippIdx;
	logic [31:0] ippLast_r [32];
	logic [31:0] ippStride_r [32];
	logic [1:0]  ippConf_r [32];
	logic [31:0] stride, ippTarget;
	logic        ippFire;
	assign ippIdx = {uopPc[3:0] ^ uopPc[7:4], uopThread};
	assign stride = uopAddr - ippLast_r[ippIdx];
	assign ippTarget = uopAddr + stride;
	// fires on a repeated stride, cacheable page, target in same page
	assign ippFire = take && !uopSwPf && uopCacheable && stride != 32'h0000_0000 &&
		stride == ippStride_r[ippIdx] && ippConf_r[ippIdx] >= 2'(tile_mem_pkg::TRAIN_HITS) &&
		ippTarget[31:12] == uopAddr[31:12];
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < 32; i++) begin
				ippLast_r[i]   <= 32'h0000_0000;
				ippStride_r[i] <= 32'h0000_0000;
				ippConf_r[i]   <= 2'h0;
			end
		end else if (take && !uopSwPf) begin
			ippLast_r[ippIdx]   <= uopAddr;
			ippStride_r[ippIdx] <= stride;
			ippConf_r[ippIdx]   <= (stride == ippStride_r[ippIdx]) ?
				((ippConf_r[ippIdx] == 2'h3) ? 2'h3 : ippConf_r[ippIdx] + 2'h1) : 2'h0;
		end
	end

	// ==========================================================
	// l2 stream detectors, shared by both threads
	logic [tile_mem_pkg::STREAMS-1:0] detHit, detPf, detAlloc;
	logic [31:0] detAddr [tile_mem_pkg::STREAMS];
	logic [5:0]  victim_r;
	logic        l2Obs;
	assign l2Obs = take && !uopSwPf && uopCacheable;
	generate
		for (g = 0; g < tile_mem_pkg::STREAMS; g++) begin : g_det
			assign detAlloc[g] = l2Obs && !(|detHit) && (victim_r == 6'(g));
			stream_detector u_det (
				.ref_clk  (ref_clk),
				.srst     (srst),
				.obsValid (l2Obs),
				.alloc    (detAlloc[g]),
				.obsAddr  (uopAddr),
				.hit      (detHit[g]),
				.pfValid  (detPf[g]),
				.pfAddr   (detAddr[g])
			);
		end
	endgenerate
	logic [31:0] l2Pick;
	always_comb begin
		l2Pick = 32'h0000_0000;
		for (int i = 0; i < tile_mem_pkg::STREAMS; i++) begin
			if (detPf[i]) begin
				l2Pick = detAddr[i];
			end
		end
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r     <= tile_mem_pkg::ST_IDLE;
			fillUsed_r  <= 3'h0;
			victim_r    <= 6'h00;
			uopReady    <= 1'b0;
			ldDone      <= 1'b0;
			ldForwarded <= 1'b0;
			l1Set       <= 6'h00;
			splitOut    <= 1'b0;
			walkReq     <= 1'b0;
			l1PfValid   <= 1'b0;
			l1PfAddr    <= 32'h0000_0000;
			l2PfValid   <= 1'b0;
			l2PfAddr    <= 32'h0000_0000;
			memPfValid  <= 1'b0;
			memPfAddr   <= 32'h0000_0000;
			fillUsed    <= 3'h0;
		end else begin
			state_r    <= state_nxt;
			fillUsed_r <= fillUsed_nxt;
			fillUsed   <= fillUsed_nxt;
			if (l2Obs && !(|detHit)) begin
				victim_r <= (victim_r == 6'(tile_mem_pkg::STREAMS-1)) ? 6'h00 :
					victim_r + 6'h01;
			end
			uopReady    <= take;
			ldDone      <= take && !uopIsStore && !uopSwPf;
			ldForwarded <= take && anyFwd;
			l1Set       <= uopAddr[11:6];
			splitOut    <= state_r == tile_mem_pkg::ST_SPLIT;
			walkReq     <= take && uopSwPf && !tlbHit;
			l1PfValid   <= ippFire;
			l1PfAddr    <= ippTarget;
			l2PfValid   <= |detPf;
			l2PfAddr    <= l2Pick;
			// misses go onward, faulting ones vanish quietly
			memPfValid  <= l2PfValid && l2PfMiss && !pfFault;
			memPfAddr   <= l2PfAddr;
		end
	end

	// ==========================================================
	// checks
	AST_SPLIT_TWO: assert property (@(posedge ref_clk) disable iff (srst)
		(state_r == tile_mem_pkg::ST_IDLE && offer && !blocked && isSplit)
		|-> !take ##1 (state_r == tile_mem_pkg::ST_SPLIT && take) ##1 uopReady)
		else $error("split access not two cycles");
	AST_NO_CONF_FWD: assert property (@(posedge ref_clk) disable iff (srst)
		anyConf |-> !take)
		else $error("conflicting load dispatched");
	AST_IPP_PAGE: assert property (@(posedge ref_clk) disable iff (srst)
		l1PfValid |-> l1PfAddr[31:12] == $past(uopAddr[31:12]))
		else $error("core prefetch crossed page");
	AST_SET_IDX: assert property (@(posedge ref_clk) disable iff (srst)
		uopReady |-> l1Set == $past(uopAddr[11:6]))
		else $error("wrong set index");
	AST_WALK: assert property (@(posedge ref_clk) disable iff (srst)
		(take && uopSwPf && !tlbHit) |=> walkReq)
		else $error("no walk on prefetch miss");
	AST_MEM_PF: assert property (@(posedge ref_clk) disable iff (srst)
		memPfValid |-> $past(l2PfValid) && $past(l2PfMiss))
		else $error("memory prefetch without l2 miss");
	AST_FILL_CAP: assert property (@(posedge ref_clk) disable iff (srst)
		fillUsed_r <= 3'(tile_mem_pkg::FILL_N))
		else $error("fill buffer overflow");
	AST_UNCACHE: assert property (@(posedge ref_clk) disable iff (srst)
		(take && !uopCacheable) |=> !l1PfValid)
		else $error("prefetch on uncacheable page");
	COV_SPLIT: cover property (@(posedge ref_clk) state_r == tile_mem_pkg::ST_SPLIT);
	COV_STALL: cover property (@(posedge ref_clk) state_r == tile_mem_pkg::ST_STALL);
	COV_FWD:   cover property (@(posedge ref_clk) ldForwarded);
	COV_L2PF:  cover property (@(posedge ref_clk) l2PfValid);
endmodule

// File: l2_partner.sv
// l2 cache and memory stand-in: prefetch answers, store drain, line fills
// assumes the bench requests drains and fills; each drain or fill answer lands 3 cycles later
`timescale 1ns/1ps
module l2_partner (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic l2PfValid,
	input  wire logic drainGo,
	input  wire logic fillGo,
	input  wire logic missMode,
	input  wire logic faultMode,
	output logic      l2PfMiss,
	output logic      pfFault,
	output logic      storeDrained,
	output logic      fillDone
);
	// ==========================================================
	// slow answers
	logic [2:0] drainDly_r;  // drain request delay line
	logic [2:0] fillDly_r;   // fill request delay line
	// answers stand with the prefetch pulse; the inverse elsewhere makes
	// a sample taken in the wrong cycle show up as a wrong answer
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			drainDly_r <= 3'h0;
			fillDly_r  <= 3'h0;
		end else begin
			drainDly_r <= {drainDly_r[1:0], drainGo};
			fillDly_r  <= {fillDly_r[1:0], fillGo};
		end
	end
	assign l2PfMiss = l2PfValid ? missMode : ~missMode;
	assign pfFault  = l2PfValid ? faultMode : ~faultMode;
	assign storeDrained = drainDly_r[2];
	assign fillDone     = fillDly_r[2];
endmodule

// File: tb_top.sv
// self-checking bench for the tile memory side block
// assumes a 100 MHz core clock; l2_partner answers drains, fills, misses
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// signals
	logic        ref_clk, srst, uopValid, uopIsStore, uopMasked, uopCacheable;
	logic        uopThread, uopSwPf, uopSwPfL1, tlbHit, storeDrained, fillDone;
	logic        l2PfMiss, pfFault, uopReady, ldDone, ldForwarded, splitOut, walkReq;
	logic        l1PfValid, l2PfValid, memPfValid, drainGo, fillGo, missMode, faultMode;
	logic        gotDone, gotFwd;   // answer flags seen with uopReady
	logic [2:0]  uopSize, fillUsed;
	logic [5:0]  l1Set;
	logic [15:0] uopPc;
	logic [19:0] pfPage;            // page all prefetches must stay in
	logic [31:0] uopAddr, l1PfAddr, l2PfAddr, memPfAddr;
	tile_mem_pkg::kind_type uopKind;
	int          n_fail, checks, nL1Pf, nL2Pf, nMemPf, nBad, nWalk, nSplit;
	tile_prefetch_and_store_forwarding i_dut (
		.ref_clk, .srst, .uopValid, .uopIsStore, .uopAddr, .uopSize, .uopKind,
		.uopMasked, .uopCacheable, .uopPc, .uopThread, .uopSwPf, .uopSwPfL1,
		.tlbHit, .storeDrained, .fillDone, .l2PfMiss, .pfFault, .uopReady,
		.ldDone, .ldForwarded, .l1Set, .splitOut, .walkReq, .l1PfValid,
		.l1PfAddr, .l2PfValid, .l2PfAddr, .memPfValid, .memPfAddr, .fillUsed
	);
	l2_partner i_l2 (
		.ref_clk, .srst, .l2PfValid, .drainGo, .fillGo, .missMode, .faultMode,
		.l2PfMiss, .pfFault, .storeDrained, .fillDone
	);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ==========================================================
	// pulse monitor: counts prefetches and flags any leaving the page
	always @(posedge ref_clk) begin
		if (l1PfValid === 1'b1) begin
			nL1Pf++;
			nBad += (l1PfAddr[31:12] !== pfPage);
		end
		if (l2PfValid === 1'b1) begin
			nL2Pf++;
			nBad += (l2PfAddr[31:12] !== pfPage);
		end
		if (memPfValid === 1'b1) begin
			nMemPf++;
			nBad += (memPfAddr[31:12] !== pfPage);
		end
		nWalk += (walkReq === 1'b1);
		nSplit += (splitOut === 1'b1);
	end
	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// offer one uop and hold it until uopReady is sampled high
	task automatic do_uop(input logic st, input logic [31:0] a, input logic [2:0] sz,
		input tile_mem_pkg::kind_type k, input logic m, input logic sp, input logic sp1,
		output int cyc);
		cyc = 0;
		{uopIsStore, uopAddr, uopSize, uopMasked, uopSwPf, uopSwPfL1} = {st, a, sz, m, sp, sp1};
		uopKind = k;
		uopValid = 1'b1;
		do begin
			@(posedge ref_clk);
			cyc++;
		end while (uopReady !== 1'b1 && cyc < 40);
		gotDone = ldDone;
		gotFwd = ldForwarded;
		if (uopReady !== 1'b1) begin
			n_fail++;
			report_and_stop();
		end
		#1 uopValid = 1'b0;
		// let one edge pass so the next offer never re-raises valid in this step
		@(posedge ref_clk);
		#1;
	endtask
	// one-cycle request to the partner; callers leave a cycle between calls
	task automatic kick(input logic d, input logic f);
		{drainGo, fillGo} = {d, f};
		@(posedge ref_clk);
		#1 {drainGo, fillGo} = 2'h0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_basic();
		int c;
		chk(32'({uopReady, ldDone, ldForwarded, l1Set, splitOut, walkReq, fillUsed}), 0);
		do_uop(1'b0, 32'h0000_0a40, 3'h2, tile_mem_pkg::KIND_INT, 1'b0, 1'b0, 1'b0, c);
		chk(32'({c[3:0], gotDone, gotFwd, l1Set}), 32'h0000_02a9);
		do_uop(1'b0, 32'h0000_1fc0, 3'h2, tile_mem_pkg::KIND_INT, 1'b0, 1'b0, 1'b0, c);
		chk(32'(l1Set), 32'h0000_003f);
		$display("test basic done");
	endtask
	// same-kind store then smaller load at a different page, same low bits
	task automatic t_forward();
		int c;
		for (int i = 0; i < 4; i++) begin
			do_uop(1'b1, 32'h0000_3100, 3'h3, tile_mem_pkg::kind_type'(i), 1'b0, 1'b0, 1'b0, c);
			do_uop(1'b0, 32'h0000_7100, 3'h2, tile_mem_pkg::kind_type'(i), 1'b0, 1'b0, 1'b0, c);
			chk(32'({c[3:0], gotDone, gotFwd}), 32'h0000_000b);
			kick(1'b1, 1'b0);
			repeat (5) @(posedge ref_clk);
			#1;
		end
		$display("test forward done");
	endtask
	// overlaps that must not forward: load waits for the drain
	task automatic t_stall();
		int c;
		logic [2:0] ss[4] = '{3'h2, 3'h3, 3'h3, 3'h3};
		logic [3:0] sk[4] = '{4'h1, 4'h0, 4'h1, 4'h1};  // store kind
		logic [3:0] lk[4] = '{4'h1, 4'h1, 4'h0, 4'h1};  // load kind
		for (int i = 0; i < 4; i++) begin
			do_uop(1'b1, 32'h0000_4200, ss[i], tile_mem_pkg::kind_type'(sk[i][1:0]), i == 3,
				1'b0, 1'b0, c);
			fork
				do_uop(1'b0, 32'h0000_4200, 3'h3, tile_mem_pkg::kind_type'(lk[i][1:0]), 1'b0,
					1'b0, 1'b0, c);
				begin
					repeat (8) @(posedge ref_clk);
					#1 kick(1'b1, 1'b0);
				end
			join
			chk(32'({c > 10, gotDone, gotFwd}), 32'h0000_0006);
		end
		$display("test stall done");
	endtask
	task automatic t_split();
		int c;
		int s0;
		s0 = nSplit;
		do_uop(1'b0, 32'h0000_003c, 3'h3, tile_mem_pkg::KIND_INT, 1'b0, 1'b0, 1'b0, c);
		chk(32'(c), 3);
		do_uop(1'b0, 32'h0000_2ffc, 3'h3, tile_mem_pkg::KIND_VEC, 1'b0, 1'b0, 1'b0, c);
		chk(32'({c[3:0], gotDone}), 32'h0000_0007);
		chk(32'(nSplit - s0), 2);
		$display("test split done");
	endtask
	// ten line-stride loads from one pc near a page edge
	task automatic t_stream(input logic [19:0] pg, input logic up, input logic th,
		input logic cch, input logic flt, input logic mss, input logic [2:0] exp);
		int c;
		int a1, a2, am;
		{a1, a2, am} = {nL1Pf, nL2Pf, nMemPf};
		{pfPage, uopThread, uopCacheable, faultMode, missMode} = {pg, th, cch, flt, mss};
		uopPc = {pg[3:0], 12'h100};
		for (int i = 0; i < 10; i++)
			do_uop(1'b0, {pg, 6'(up ? 54 + i : 9 - i), 6'h00}, 3'h3, tile_mem_pkg::KIND_INT,
				1'b0, 1'b0, 1'b0, c);
		repeat (6) @(posedge ref_clk);
		#1 chk(32'({nL1Pf > a1, nL2Pf > a2, nMemPf > am}), 32'(exp));
		chk(32'(nBad), 0);
		$display("test stream done");
	endtask
	task automatic t_swpf();
		int c;
		int w0;
		w0 = nWalk;
		pfPage = 20'h0_0009;
		tlbHit = 1'b0;
		for (int i = 0; i < 4; i++)
			do_uop(1'b0, 32'h0000_9000 + 32'(i * 64), 3'h0, tile_mem_pkg::KIND_INT, 1'b0,
				1'b1, 1'b1, c);
		chk(32'({fillUsed, 4'(nWalk - w0)}), 32'h0000_0044);
		tlbHit = 1'b1;
		do_uop(1'b0, 32'h0000_9400, 3'h0, tile_mem_pkg::KIND_INT, 1'b0, 1'b1, 1'b0, c);
		chk(32'({c[3:0], fillUsed}), 32'h0000_0014);
		fork
			do_uop(1'b0, 32'h0000_9800, 3'h0, tile_mem_pkg::KIND_INT, 1'b0, 1'b1, 1'b1, c);
			begin
				repeat (8) @(posedge ref_clk);
				#1 kick(1'b0, 1'b1);
			end
		join
		chk(32'(c > 10), 1);
		for (int i = 0; i < 4; i++) begin
			kick(1'b0, 1'b1);
			@(posedge ref_clk);
			#1;
		end
		repeat (5) @(posedge ref_clk);
		#1 chk(32'(fillUsed), 0);
		$display("test swpf done");
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{uopValid, uopIsStore, uopMasked, uopThread, uopSwPf, uopSwPfL1} = 6'h00;
		{drainGo, fillGo, faultMode, pfPage, uopAddr, uopSize, uopPc} = '0;
		{uopCacheable, tlbHit, missMode, srst} = 4'hf;
		uopKind = tile_mem_pkg::KIND_INT;
		repeat (5) @(posedge ref_clk);
		#1 srst = 1'b0;
		t_basic();
		t_forward();
		t_stall();
		t_split();
		t_stream(20'h0_0005, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h7);
		t_stream(20'h0_0006, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 3'h7);
		t_stream(20'h0_0007, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0);
		t_stream(20'h0_0008, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h6);
		t_stream(20'h0_000a, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h6);
		missMode = 1'b1;
		t_swpf();
		report_and_stop();
	end
endmodule
